/* File: bench/quad_volume_serial_ctrl_tb.sv */
// Self-checking testbench for the four-channel serial volume control.
module quad_volume_serial_ctrl_tb import qvs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic mute_n = 1'b1;
  logic zero_cross_enable = 1'b0;
  logic sup_low = 1'b0;
  logic cal_done = 1'b0;
  logic [3:0] zc = 4'h0;
  logic sclk, cs_n, din, dout, oe, cal_start, cal_busy, por;
  gain_word_t gain;
  logic [3:0] swm, hwm;
  logic [31:0] w, a, b;
  int fail_count = 0;
  int compares = 0;
  int starts = 0;
  int s0;

  // ****************************************************************
  // Clock, instances and monitors
  // ****************************************************************
  // Core clock of 25 ns.
  always #12.5 core_clk = ~core_clk;

  quad_volume_serial_ctrl #(.POR_CYCLES(50), .ZC_TIMEOUT_CYCLES(20)) i_quad_volume_serial_ctrl (
    .CORE_CLK_I(core_clk), .RESET_I(reset), .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_DIN_I(din),
    .SERIAL_DOUT_O(dout), .SERIAL_DOUT_OE_O(oe), .MUTE_N_I(mute_n), .ZERO_CROSS_ENABLE_I(zero_cross_enable),
    .SUPPLY_LOW_I(sup_low), .ZC_ABOVE_I(zc), .CAL_DONE_I(cal_done), .CAL_START_O(cal_start),
    .CAL_BUSY_O(cal_busy), .POR_ACTIVE_O(por), .GAIN_O(gain), .SW_MUTE_O(swm), .HW_MUTE_O(hwm));

  qvs_host_model i_qvs_host_model (.clk_i(core_clk), .dout_i(dout), .dout_oe_i(oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));

  // Counts calibration start pulses.
  always @(posedge core_clk) begin
    if (cal_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits n core clock cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Channels whose code is zero, channel one in bit 0.
  function automatic logic [3:0] zmask(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      zmask[i] = (v[i * 8 +: 8] == 8'h00);
    end
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Power-up, writes, chaining, crossing wait, mutes and supply loss.
  initial begin
    void'($urandom(50));
    cyc(2);
    reset <= 1'b0;
    cyc(2);
    chk("por", 32'h1, por);
    chk("hwm", 32'hf, hwm);
    chk("gain", 32'h0, gain);
    cyc(60);
    chk("starts", 32'h1, starts);
    chk("busy", 32'h1, cal_busy);
    cal_done <= 1'b1;
    cyc(8);
    cal_done <= 1'b0;
    chk("busy", 32'h0, cal_busy);
    chk("gain", 32'h0, gain);
    chk("swm", 32'hf, swm);
    chk("oe", 32'h0, oe);
    cyc(25);
    chk("hwm", 32'h0, hwm);
    // Random words plus one with a zero code and boundary codes.
    for (int k = 0; k < 5; k++) begin
      w = (k == 0) ? 32'h00ff0180 : $urandom;
      i_qvs_host_model.send({32'h0, w}, 32);
      cyc(6);
      chk("gain", w, gain);
      chk("swm", zmask(w), swm);
      chk("oe_frame", 32'h1, i_qvs_host_model.oe_all);
      chk("oe_idle", 32'h0, oe);
    end
    // Short frame and clocks while deselected leave the gains alone.
    i_qvs_host_model.send({32'h0, ~w}, 31);
    cyc(6);
    chk("gain", w, gain);
    i_qvs_host_model.noise(40);
    cyc(6);
    chk("gain", w, gain);
    // Two words through one device: the first leaves on the serial output.
    a = $urandom;
    b = $urandom;
    i_qvs_host_model.send({a, b}, 64);
    cyc(6);
    chk("gain", b, gain);
    chk("chain", a, i_qvs_host_model.rx[31:0]);
    // Crossing wait: channel one crosses, the rest time out.
    zero_cross_enable <= 1'b1;
    w = ~b;
    i_qvs_host_model.send({32'h0, w}, 32);
    cyc(8);
    chk("gain", b, gain);
    zc <= 4'h1;
    cyc(7);
    chk("gain", {b[31:8], w[7:0]}, gain);
    cyc(20);
    chk("gain", w, gain);
    zc <= 4'h0;
    zero_cross_enable <= 1'b0;
    // Hardware mute waits for a crossing or timeout and starts calibration.
    s0 = starts;
    mute_n <= 1'b0;
    cyc(6);
    chk("hwm", 32'h0, hwm);
    chk("starts", s0 + 1, starts);
    // Channel two crosses first and mutes before the others time out.
    zc <= 4'h2;
    cyc(6);
    chk("hwm", 32'h2, hwm);
    cyc(19);
    chk("hwm", 32'hf, hwm);
    zc <= 4'h0;
    cal_done <= 1'b1;
    cyc(6);
    cal_done <= 1'b0;
    mute_n <= 1'b1;
    cyc(30);
    chk("hwm", 32'h0, hwm);
    chk("gain", w, gain);
    // Supply loss mutes at once and reruns power-up.
    sup_low <= 1'b1;
    cyc(6);
    chk("hwm", 32'hf, hwm);
    sup_low <= 1'b0;
    cyc(6);
    chk("por", 32'h1, por);
    cyc(60);
    chk("starts", s0 + 2, starts);
    stop_test();
  end

  // Cuts a hang short well after the expected run of about 3000 cycles.
  initial begin
    #300000;
    fail_count++;
    stop_test();
  end
endmodule

/* File: bench/qvs_host_model.sv */
// Host model that drives the three-wire serial port and captures the chained output.
module qvs_host_model (
  // Clock
  input wire logic clk_i,
  // Device serial output
  input wire logic dout_i,
  input wire logic dout_oe_i,
  // Serial lines driven by the host
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_reg = 1'b0;
  logic cs_reg = 1'b1;
  logic din_reg = 1'b0;
  logic idle_reg = 1'b0;
  logic oe_all = 1'b0;
  logic [63:0] rx = 64'h0;

  // ****************************************************************
  // Line levels
  // ****************************************************************
  // Data toggles while deselected so a stale bit can never look valid.
  always @(posedge clk_i) begin
    idle_reg <= ~idle_reg;
  end
  assign sclk_o = sclk_reg;
  assign cs_n_o = cs_reg;
  assign din_o = cs_reg ? idle_reg : din_reg;

  // ****************************************************************
  // Transfers
  // ****************************************************************
  // One half period of the 200 ns serial clock.
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask

  // Sends n bits, top bit first, and keeps select low for n+1 clock periods.
  task automatic send(input logic [63:0] w, input int n);
    cs_reg <= 1'b0;
    oe_all = 1'b1;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      din_reg <= w[i];
      half();
      sclk_reg <= 1'b1;
      oe_all = oe_all & dout_oe_i;
      half();
      rx = {rx[62:0], dout_oe_i ? dout_i : ~dout_i};
      sclk_reg <= 1'b0;
    end
    half();
    cs_reg <= 1'b1;
    half();
  endtask

  // Clock pulses with select held high, which the device must ignore.
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_reg <= 1'b1;
      half();
      sclk_reg <= 1'b0;
      half();
    end
  endtask
endmodule

/* File: verilog/quad_volume_serial_ctrl.sv */
// Digital control of a four-channel volume controller with a three-wire serial port.
//
// Function
// - After power up hold reset about 100 ms, in hardware mute, all state cleared.
// - When the reset period ends, calibration starts by itself.
// - After the power-up calibration all four gain codes become 00, kept until written.
// - Supply low forces hardware mute; recovery reruns the full power-up sequence.
// - Serial data is taken only while chip select is low.
// - Codes travel most significant bit first, as unsigned binary.
// - Serial input is sampled on each rising serial clock edge.
// - Serial output is high impedance while chip select is high.
// - Serial output changes on the falling serial clock edge.
// - Code zero mutes the channel by grounding its amplifier input.
// - Codes 1 to 255 give 31.5 minus half of (255 minus code) dB.
// - The shift path is 32 bits and feeds the serial output onward.
// - Zero-cross enable low disables crossing wait; high enables it.
// - Enabled, a change waits for a rising crossing or 16 ms.
// - Hardware mute applies on a crossing or 16 ms, whatever the enable.
// - Asserting hardware mute starts a new calibration.
// - Writing zero selects software mute: unity gain, grounded input.
// - Hardware mute input is active low.
`include "qvs_consts.svh"

module quad_volume_serial_ctrl import qvs_pkg::*; #(
  parameter int POR_CYCLES = `QVS_POR_CYCLES,
  parameter int ZC_TIMEOUT_CYCLES = `QVS_ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  // Serial control port
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SERIAL_DIN_I,
  output logic SERIAL_DOUT_O,
  output logic SERIAL_DOUT_OE_O,
  // Control pins
  input wire logic MUTE_N_I,
  input wire logic ZERO_CROSS_ENABLE_I,
  input wire logic SUPPLY_LOW_I,
  // Analog side
  input wire logic [3:0] ZC_ABOVE_I,
  input wire logic CAL_DONE_I,
  output logic CAL_START_O,
  output logic CAL_BUSY_O,
  output logic POR_ACTIVE_O,
  output gain_word_t GAIN_O,
  output logic [3:0] SW_MUTE_O,
  output logic [3:0] HW_MUTE_O
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic sclk_meta_reg, sclk_sync_reg, sclk_last_reg;
  logic cs_meta_reg, cs_sync_reg, cs_last_reg;
  logic din_meta_reg, din_sync_reg;
  logic mute_meta_reg, mute_sync_reg, mute_last_reg;
  logic zce_meta_reg, zce_sync_reg;
  logic low_meta_reg, low_sync_reg;
  logic cal_meta_reg, cal_sync_reg, cal_last_reg;
  logic [3:0] zc_meta_reg, zc_sync_reg, zc_last_reg;

  // Two flip-flops per pin; the third stage only serves edge detection.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_last_reg <= 1'b0;
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_last_reg <= 1'b1;
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
      mute_meta_reg <= 1'b1;
      mute_sync_reg <= 1'b1;
      mute_last_reg <= 1'b1;
      zce_meta_reg <= 1'b0;
      zce_sync_reg <= 1'b0;
      low_meta_reg <= 1'b0;
      low_sync_reg <= 1'b0;
      cal_meta_reg <= 1'b0;
      cal_sync_reg <= 1'b0;
      cal_last_reg <= 1'b0;
      zc_meta_reg <= 4'h0;
      zc_sync_reg <= 4'h0;
      zc_last_reg <= 4'h0;
    end else begin
      sclk_meta_reg <= SCLK_I;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_last_reg <= sclk_sync_reg;
      cs_meta_reg <= CS_N_I;
      cs_sync_reg <= cs_meta_reg;
      cs_last_reg <= cs_sync_reg;
      din_meta_reg <= SERIAL_DIN_I;
      din_sync_reg <= din_meta_reg;
      mute_meta_reg <= MUTE_N_I;
      mute_sync_reg <= mute_meta_reg;
      mute_last_reg <= mute_sync_reg;
      zce_meta_reg <= ZERO_CROSS_ENABLE_I;
      zce_sync_reg <= zce_meta_reg;
      low_meta_reg <= SUPPLY_LOW_I;
      low_sync_reg <= low_meta_reg;
      cal_meta_reg <= CAL_DONE_I;
      cal_sync_reg <= cal_meta_reg;
      cal_last_reg <= cal_sync_reg;
      zc_meta_reg <= ZC_ABOVE_I;
      zc_sync_reg <= zc_meta_reg;
      zc_last_reg <= zc_sync_reg;
    end
  end

  // Edge events seen on the core clock.
  logic sclk_rise, sclk_fall, cs_low, cs_rise, mute_fall, cal_done_rise;
  logic [3:0] zc_pos;
  assign sclk_rise = sclk_sync_reg & ~sclk_last_reg;
  assign sclk_fall = ~sclk_sync_reg & sclk_last_reg;
  assign cs_low = ~cs_sync_reg;
  assign cs_rise = cs_sync_reg & ~cs_last_reg;
  assign mute_fall = ~mute_sync_reg & mute_last_reg;
  assign cal_done_rise = cal_sync_reg & ~cal_last_reg;
  assign zc_pos = zc_sync_reg & ~zc_last_reg;

  // ****************************************************************
  // Life cycle: power-up reset, calibration, run, supply low
  // ****************************************************************
  life_state_t state_reg, state_next;
  logic [`QVS_POR_CNT_W-1:0] por_cnt_reg, por_cnt_next;
  logic cal_busy_reg, cal_busy_next;
  logic cal_start_reg, cal_start_next;
  logic cal_finish;

  assign cal_finish = (state_reg == ST_CAL) && cal_done_rise && !low_sync_reg;

  // Sequencing; a low supply overrides every other state.
  always_comb begin
    state_next = state_reg;
    por_cnt_next = por_cnt_reg;
    cal_busy_next = cal_busy_reg;
    cal_start_next = 1'b0;
    case (state_reg)
      ST_POR: begin
        cal_busy_next = 1'b0;
        if (por_cnt_reg == `QVS_POR_CNT_W'(POR_CYCLES - 1)) begin
          state_next = ST_CAL;
          por_cnt_next = '0;
          cal_start_next = 1'b1;
          cal_busy_next = 1'b1;
        end else begin
          por_cnt_next = por_cnt_reg + `QVS_POR_CNT_W'(1);
        end
      end
      ST_CAL: begin
        if (cal_done_rise) begin
          state_next = ST_RUN;
          cal_busy_next = 1'b0;
        end
      end
      ST_RUN: begin
        if (cal_busy_reg && cal_done_rise) begin
          cal_busy_next = 1'b0;
        end else if (!cal_busy_reg && mute_fall) begin
          cal_start_next = 1'b1;
          cal_busy_next = 1'b1;
        end
      end
      ST_LOW: begin
        cal_busy_next = 1'b0;
        if (!low_sync_reg) begin
          state_next = ST_POR;
          por_cnt_next = '0;
        end
      end
      default: begin
        state_next = ST_POR;
        por_cnt_next = '0;
        cal_busy_next = 1'b0;
      end
    endcase
    if (low_sync_reg) begin
      state_next = ST_LOW;
      cal_start_next = 1'b0;
      cal_busy_next = 1'b0;
    end
  end

  // Registers only.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_POR;
      por_cnt_reg <= '0;
      cal_busy_reg <= 1'b0;
      cal_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      por_cnt_reg <= por_cnt_next;
      cal_busy_reg <= cal_busy_next;
      cal_start_reg <= cal_start_next;
    end
  end

  // ****************************************************************
  // Serial shift path and gain word
  // ****************************************************************
  logic [`QVS_WORD_BITS-1:0] shift_reg, shift_next;
  logic [`QVS_BIT_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
  logic dout_reg, dout_next;
  gain_word_t target_reg, target_next;

  // Shift on rising clock, present on falling, commit a whole word on deselect.
  always_comb begin
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    dout_next = dout_reg;
    target_next = target_reg;
    if (state_reg == ST_POR) begin
      shift_next = '0;
      bit_cnt_next = '0;
      dout_next = 1'b0;
      target_next = `QVS_GAIN_RESET;
    end else begin
      if (cs_low) begin
        if (sclk_rise) begin
          shift_next = {shift_reg[`QVS_WORD_BITS-2:0], din_sync_reg};
          if (bit_cnt_reg != `QVS_WORD_FULL) begin
            bit_cnt_next = bit_cnt_reg + `QVS_BIT_CNT_W'(1);
          end
        end
        if (sclk_fall) begin
          dout_next = shift_reg[`QVS_WORD_BITS-1];
        end
      end else begin
        bit_cnt_next = '0;
        if (cs_rise && bit_cnt_reg == `QVS_WORD_FULL && state_reg == ST_RUN) begin
          target_next = gain_word_t'(shift_reg);
        end
      end
      if (cal_finish) begin
        target_next = `QVS_GAIN_RESET;
      end
    end
  end

  // Registers only.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      dout_reg <= 1'b0;
      target_reg <= `QVS_GAIN_RESET;
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      dout_reg <= dout_next;
      target_reg <= target_next;
    end
  end

  // ****************************************************************
  // Channel gates
  // ****************************************************************
  chan_set_t active [4];
  logic hold_mute;
  // Outside the run state the mute and codes take effect at once.
  assign hold_mute = (state_reg != ST_RUN);

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    chan_set_t want;
    assign want.hw_mute = hold_mute | ~mute_sync_reg;
    assign want.code = code_of(target_reg, 2'(ch));
    qvs_chan_gate #(
      .TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)
    ) u_gate (
      .clk_i(CORE_CLK_I),
      .rst_i(RESET_I),
      .want_i(want),
      .zc_en_i(zce_sync_reg),
      .zc_pulse_i(zc_pos[ch]),
      .bypass_i(hold_mute),
      .active_o(active[ch]),
      .sw_mute_o(SW_MUTE_O[ch]),
      .pending_o()
    );
    assign HW_MUTE_O[ch] = active[ch].hw_mute;
  end

  // Active codes select the resistor taps directly, half-dB steps.
  assign GAIN_O = '{ch4: active[3].code, ch3: active[2].code, ch2: active[1].code, ch1: active[0].code};

  // Port outputs.
  assign SERIAL_DOUT_O = dout_reg;
  assign SERIAL_DOUT_OE_O = cs_low;
  assign CAL_START_O = cal_start_reg;
  assign CAL_BUSY_O = cal_busy_reg;
  assign POR_ACTIVE_O = (state_reg == ST_POR);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_por_muted;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      ($past(state_reg) == ST_POR && state_reg == ST_POR) |-> (HW_MUTE_O == 4'hf && target_reg == '0);
  endproperty
  a_por_muted: assert property (p_por_muted) else $error("Not muted or cleared during power-up.");

  property p_por_to_cal;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (state_reg == ST_POR && por_cnt_reg == `QVS_POR_CNT_W'(POR_CYCLES - 1) && !low_sync_reg)
        |=> (state_reg == ST_CAL && CAL_START_O && CAL_BUSY_O);
  endproperty
  a_por_to_cal: assert property (p_por_to_cal) else $error("Calibration did not follow power-up.");

  property p_cal_zero;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      cal_finish |=> (target_reg == '0 && state_reg == ST_RUN);
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("Codes not zero after calibration.");

  property p_low_supply;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      low_sync_reg |=> (state_reg == ST_LOW) ##1 (HW_MUTE_O == 4'hf);
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("Low supply did not mute.");

  property p_cs_ignore;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (cs_sync_reg && state_reg != ST_POR) |=> (shift_reg == $past(shift_reg));
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("Shift moved while deselected.");

  property p_sample_rise;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (cs_low && sclk_rise && state_reg != ST_POR)
        |=> (shift_reg == {$past(shift_reg[30:0]), $past(din_sync_reg)});
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("Input bit not shifted in.");

  property p_oe_off;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      CS_N_I [*3] |-> !SERIAL_DOUT_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Output driven while deselected.");

  property p_dout_fall;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (cs_low && sclk_fall && state_reg != ST_POR) |=> (SERIAL_DOUT_O == $past(shift_reg[31]));
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("Output bit not moved on falling edge.");

  property p_commit;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (cs_rise && bit_cnt_reg == `QVS_WORD_FULL && state_reg == ST_RUN && !low_sync_reg)
        |=> (target_reg == $past(shift_reg));
  endproperty
  a_commit: assert property (p_commit) else $error("Full word not committed on deselect.");

  property p_partial;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (state_reg == ST_RUN && !(cs_rise && bit_cnt_reg == `QVS_WORD_FULL) && !low_sync_reg)
        |=> (target_reg == $past(target_reg));
  endproperty
  a_partial: assert property (p_partial) else $error("Gains altered by a partial shift.");

  property p_mute_cal;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
      (state_reg == ST_RUN && mute_fall && !cal_busy_reg && !low_sync_reg) |=> (CAL_START_O ##1 !CAL_START_O);
  endproperty
  a_mute_cal: assert property (p_mute_cal) else $error("Hardware mute did not start calibration.");

endmodule

/* File: verilog/qvs_chan_gate.sv */
// Per-channel gate that applies a new setting on a rising zero crossing or timeout.
`include "qvs_consts.svh"

module qvs_chan_gate import qvs_pkg::*; #(
  parameter int TIMEOUT_CYCLES = `QVS_ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requested setting and conditions
  input wire chan_set_t want_i,
  input wire logic zc_en_i,
  input wire logic zc_pulse_i,
  input wire logic bypass_i,
  // Setting in effect
  output chan_set_t active_o,
  output logic sw_mute_o,
  output logic pending_o
);

  // ****************************************************************
  // Gate state
  // ****************************************************************
  chan_set_t active_reg;
  chan_set_t active_next;
  logic [`QVS_ZC_CNT_W-1:0] timer_reg;
  logic [`QVS_ZC_CNT_W-1:0] timer_next;
  logic changed;
  logic zc_use;
  logic timed_out;

  // Unless bypassed, a hardware mute change waits for a crossing or the timeout, whatever the enable pin says.
  assign changed = (want_i != active_reg);
  assign zc_use = zc_en_i | (want_i.hw_mute != active_reg.hw_mute);
  assign timed_out = (timer_reg == `QVS_ZC_CNT_W'(TIMEOUT_CYCLES - 1));

  // Next setting and timeout count.
  always_comb begin
    active_next = active_reg;
    timer_next = timer_reg;
    if (bypass_i) begin
      active_next = want_i;
      timer_next = '0;
    end else if (!changed) begin
      timer_next = '0;
    end else if (!zc_use || zc_pulse_i || timed_out) begin
      active_next = want_i;
      timer_next = '0;
    end else begin
      timer_next = timer_reg + `QVS_ZC_CNT_W'(1);
    end
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= '{hw_mute: 1'b1, code: `QVS_CODE_SOFT_MUTE};
      timer_reg <= '0;
    end else begin
      active_reg <= active_next;
      timer_reg <= timer_next;
    end
  end

  assign active_o = active_reg;
  assign sw_mute_o = is_soft_mute(active_reg.code);
  assign pending_o = changed;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_zc_off_direct;
    @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && changed && !zc_en_i && want_i.hw_mute == active_reg.hw_mute) |=> active_o == $past(want_i);
  endproperty
  a_zc_off_direct: assert property (p_zc_off_direct) else $error("Gain change delayed with crossing off.");

  property p_zc_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && changed && zc_use && !zc_pulse_i && !timed_out) |=> active_o == $past(active_o);
  endproperty
  a_zc_hold: assert property (p_zc_hold) else $error("Gain changed before crossing or timeout.");

  property p_timeout_apply;
    @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && changed && timed_out) |=> active_o == $past(want_i);
  endproperty
  a_timeout_apply: assert property (p_timeout_apply) else $error("Timeout did not apply the setting.");

  property p_mute_on_cross;
    @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && want_i.hw_mute && !active_reg.hw_mute && zc_pulse_i) |=> active_o.hw_mute;
  endproperty
  a_mute_on_cross: assert property (p_mute_on_cross) else $error("Hardware mute missed a crossing.");

endmodule

/* File: verilog/qvs_consts.svh */
// Constant definitions for the four-channel serial volume control logic.
`ifndef QVS_CONSTS_SVH
`define QVS_CONSTS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define QVS_CLK_PERIOD_NS 25
`define QVS_POR_TIME_MS 100
`define QVS_ZC_TIMEOUT_MS 16
`define QVS_POR_CYCLES ((`QVS_POR_TIME_MS * 1000000) / `QVS_CLK_PERIOD_NS)
`define QVS_ZC_TIMEOUT_CYCLES ((`QVS_ZC_TIMEOUT_MS * 1000000) / `QVS_CLK_PERIOD_NS)
`define QVS_POR_CNT_W 23
`define QVS_ZC_CNT_W 20

// ****************************************************************
// Serial word layout and reset values
// ****************************************************************
`define QVS_WORD_BITS 32
`define QVS_BIT_CNT_W 6
`define QVS_WORD_FULL 6'h20
`define QVS_CODE_BITS 8
`define QVS_CODE_SOFT_MUTE 8'h00
`define QVS_GAIN_RESET 32'h00000000

`endif

/* File: verilog/qvs_pkg.sv */
// Types and helper functions shared by the volume control design files.
package qvs_pkg;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Gain word as shifted in: channel four occupies the first byte sent.
  typedef struct packed {
    logic [7:0] ch4;
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
  } gain_word_t;

  // One channel setting: hardware mute request plus gain code.
  typedef struct packed {
    logic hw_mute;
    logic [7:0] code;
  } chan_set_t;

  // Device life cycle, one-hot.
  typedef enum logic [3:0] {
    ST_POR = 4'b0001,
    ST_CAL = 4'b0010,
    ST_RUN = 4'b0100,
    ST_LOW = 4'b1000
  } life_state_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Picks the code of channel idx+1 out of a gain word.
  function automatic logic [7:0] code_of(input gain_word_t w, input logic [1:0] idx);
    logic [31:0] flat;
    flat = w;
    code_of = flat[idx * 8 +: 8];
  endfunction

  // A zero code selects the grounded-input, unity-gain mute.
  function automatic logic is_soft_mute(input logic [7:0] code);
    is_soft_mute = (code == 8'h00);
  endfunction

endpackage
